// *** inc/lnb_i2c_regs.svh ***
// Constants of the regulator controller I2C slave: address, register layout, readback map
`ifndef LNB_I2C_REGS_SVH
`define LNB_I2C_REGS_SVH

// Slave address with both straps low, and the strap width
`define LNB_SLAVE_ADDR_BASE 7'h08
`define LNB_ADDR_W 7
`define LNB_STRAP_W 2

// Write byte layout: register select on top, data below
`define LNB_SEL_MSB 7
`define LNB_SEL_LSB 5
`define LNB_REG_W 5
`define LNB_NUM_SYS_REGS 8
`define LNB_EN_BIT 4
`define LNB_REG_RESET 5'h00

// Register indices that drive the two channels
`define LNB_FIRST_REG 3'h0
`define LNB_SECOND_REG 3'h1

// Readback sequence: the system registers, then one diagnostic byte per channel
`define LNB_PTR_W 4
`define LNB_READ_BYTES 4'ha
`define LNB_DIAG1_PTR 4'h8
`define LNB_DIAG2_PTR 4'h9

// Diagnostic byte bit positions
`define LNB_DIAG_OTF_BIT 0
`define LNB_DIAG_CUR_BIT 1
`define LNB_DIAG_VOLT_BIT 2
`define LNB_DIAG_TPR_BIT 3
`define LNB_DIAG_TTH_BIT 4

// Bit counting within a byte
`define LNB_CNT_W 4
`define LNB_BITS_PER_BYTE 4'h8

`endif

// *** inc/lnb_i2c_pkg.sv ***
// Types shared by the regulator controller I2C slave
package lnb_i2c_pkg;
  `include "lnb_i2c_regs.svh"

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_WR_DATA,
    LINK_WR_ACK,
    LINK_RD_DATA,
    LINK_RD_ACK,
    LINK_IGNORE
  } link_state_t;

  typedef logic [`LNB_REG_W-1:0] sys_word_t;
  typedef sys_word_t [`LNB_NUM_SYS_REGS-1:0] sys_bank_t;

  // Link domain state
  typedef struct packed {
    link_state_t state;
    logic scl_q;
    logic sda_q;
    logic [`LNB_CNT_W-1:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic master_ack;
    logic [`LNB_PTR_W-1:0] rd_ptr;
    logic sda_oe;
    logic sda_level;
    sys_bank_t shadow;
    logic wr_valid;
    logic [7:0] wr_word;
  } link_regs_t;

  // Core domain state
  typedef struct packed {
    sys_bank_t bank;
  } core_regs_t;
endpackage

// *** hw/bit_sync.sv ***
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_regs_t;

  sync_regs_t r;
  sync_regs_t next_r;

  // First stage feeds only the second
  always_comb begin
    next_r = r;
    next_r.meta = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;
endmodule

// *** hw/word_cross.sv ***
// Word crossing: data held in the source, toggle request synchronised to the destination
`timescale 1ns/1ps
module word_cross #(
  parameter int WIDTH = 8
) (
  // Source side
  input wire logic src_clk_in,
  input wire logic src_valid_in,
  input wire logic [WIDTH-1:0] src_data_in,
  // Destination side
  input wire logic dst_clk_in,
  output logic dst_valid_out,
  output logic [WIDTH-1:0] dst_data_out,
  // Reset for both sides
  input wire logic reset_in
);
  typedef struct packed {
    logic req;
    logic [WIDTH-1:0] data;
  } src_regs_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic valid;
    logic [WIDTH-1:0] data;
  } dst_regs_t;

  src_regs_t s;
  src_regs_t next_s;
  dst_regs_t d;
  dst_regs_t next_d;

  // Data and toggle change together; data is stable long before the toggle arrives
  always_comb begin
    next_s = s;
    if (src_valid_in) begin
      next_s.req = ~s.req;
      next_s.data = src_data_in;
    end
  end

  always_ff @(posedge src_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Edge seen between stages two and three only
  always_comb begin
    next_d = d;
    next_d.s1 = s.req;
    next_d.s2 = d.s1;
    next_d.s3 = d.s2;
    next_d.valid = d.s2 ^ d.s3;
    if (d.s2 ^ d.s3) begin
      next_d.data = s.data;
    end
  end

  always_ff @(posedge dst_clk_in or posedge reset_in) begin
    if (reset_in) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign dst_valid_out = d.valid;
  assign dst_data_out = d.data;
endmodule

// *** hw/lnb_i2c_slave_readback_por.sv ***
// I2C slave front end of a dual-channel regulator controller, with power-good reset
// What this block does
// - A read-addressed transfer makes the slave shift out register bytes MSB first.
// - On the ninth clock of each read byte a master ack asks for more, a nack ends the read.
// - Readback carries read-only current, voltage, tone-present and overtemp flags.
// - With power-good low all bus traffic is ignored and never acknowledged.
// - With power-good low the first and second system registers are held at zero.
// - With power-good high the interface works and accepts register writes.
// - Channel enables are zero after power-up and never rise before their control data.
// - Slave address is 0001000 with the two straps giving the low two bits.
// - Each tone threshold flag follows that channel's tone-detect pin.
// - Each channel has its own enable bit that switches off only that channel.
`timescale 1ns/1ps
`include "lnb_i2c_regs.svh"
module lnb_i2c_slave_readback_por
  import lnb_i2c_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic link_clk_in,
  input wire logic reset_in,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Address straps and supply status
  input wire logic addr_strap_low_in,
  input wire logic addr_strap_high_in,
  input wire logic power_good_in,
  // Diagnostic pins
  input wire logic ch1_current_range_flag_in,
  input wire logic ch2_current_range_flag_in,
  input wire logic ch1_voltage_range_flag_in,
  input wire logic ch2_voltage_range_flag_in,
  input wire logic ch1_tone_present_flag_in,
  input wire logic ch2_tone_present_flag_in,
  input wire logic overtemp_fault_flag_in,
  input wire logic ch1_tone_detect_pin_in,
  input wire logic ch2_tone_detect_pin_in,
  // Channel control
  output logic ch1_output_enable_out,
  output logic ch2_output_enable_out,
  output logic [3:0] ch1_control_out,
  output logic [3:0] ch2_control_out,
  output logic [`LNB_NUM_SYS_REGS*`LNB_REG_W-1:0] config_regs_out,
  output logic interface_ready_out
);
  localparam int LINK_SYNC_W = 14;
  // Named so that its upper bits can be selected; a bare literal cannot be sliced
  localparam logic [`LNB_ADDR_W-1:0] SLAVE_ADDR_BASE = `LNB_SLAVE_ADDR_BASE;

  link_regs_t link;
  link_regs_t next_link;
  core_regs_t core;
  core_regs_t next_core;

  logic [LINK_SYNC_W-1:0] link_sync;
  logic scl_s;
  logic sda_s;
  logic pg_link;
  logic strap_hi_s;
  logic strap_lo_s;
  logic tdet2_s;
  logic tdet1_s;
  logic otf_s;
  logic ch2_tone_present_flag_s;
  logic ch1_tone_present_flag_s;
  logic volt2_s;
  logic volt1_s;
  logic cur2_s;
  logic cur1_s;
  logic pg_core;
  logic wr_valid_core;
  logic [7:0] wr_word_core;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [`LNB_ADDR_W-1:0] slave_addr;
  logic [7:0] tx_byte;

  // Next readback position, wrapping after the last diagnostic byte
  function automatic logic [`LNB_PTR_W-1:0] bump_ptr(input logic [`LNB_PTR_W-1:0] ptr);
    logic [`LNB_PTR_W-1:0] last;
    last = `LNB_READ_BYTES - `LNB_PTR_W'(1);
    if (ptr == last) begin
      return '0;
    end
    return ptr + `LNB_PTR_W'(1);
  endfunction

  // One diagnostic byte for a channel; overtemp is shared by both
  function automatic logic [7:0] diag_byte(input logic cur, input logic volt,
                                           input logic tpr, input logic tth, input logic overtemp_fault_flag);
    logic [7:0] b;
    b = 8'h00;
    b[`LNB_DIAG_OTF_BIT] = overtemp_fault_flag;
    b[`LNB_DIAG_CUR_BIT] = cur;
    b[`LNB_DIAG_VOLT_BIT] = volt;
    b[`LNB_DIAG_TPR_BIT] = tpr;
    b[`LNB_DIAG_TTH_BIT] = tth;
    return b;
  endfunction

  // All asynchronous pins enter the link domain through two flops
  bit_sync #(
    .WIDTH(LINK_SYNC_W)
  ) link_pin_sync (
    .clk_in(link_clk_in),
    .reset_in(reset_in),
    .async_in({power_good_in, addr_strap_high_in, addr_strap_low_in,
               ch2_tone_detect_pin_in, ch1_tone_detect_pin_in, overtemp_fault_flag_in,
               ch2_tone_present_flag_in, ch1_tone_present_flag_in,
               ch2_voltage_range_flag_in, ch1_voltage_range_flag_in,
               ch2_current_range_flag_in, ch1_current_range_flag_in, sda_in, scl_in}),
    .sync_out(link_sync)
  );

  assign {pg_link, strap_hi_s, strap_lo_s, tdet2_s, tdet1_s, otf_s, ch2_tone_present_flag_s, ch1_tone_present_flag_s,
          volt2_s, volt1_s, cur2_s, cur1_s, sda_s, scl_s} = link_sync;

  // Power-good seen separately in the core domain
  bit_sync #(
    .WIDTH(1)
  ) core_pg_sync (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .async_in(power_good_in),
    .sync_out(pg_core)
  );

  // Bus events from the synchronised pins
  assign scl_rise = scl_s & ~link.scl_q;
  assign scl_fall = ~scl_s & link.scl_q;
  assign start_seen = scl_s & link.scl_q & link.sda_q & ~sda_s;
  assign stop_seen = scl_s & link.scl_q & ~link.sda_q & sda_s;

  // Straps fill the low two address bits
  assign slave_addr = {SLAVE_ADDR_BASE[`LNB_ADDR_W-1:`LNB_STRAP_W],
                       strap_hi_s, strap_lo_s};

  // Byte to send at the current readback position
  always_comb begin
    tx_byte = 8'h00;
    if (link.rd_ptr == `LNB_DIAG1_PTR) begin
      tx_byte = diag_byte(cur1_s, volt1_s, ch1_tone_present_flag_s, tdet1_s, otf_s);
    end else if (link.rd_ptr == `LNB_DIAG2_PTR) begin
      tx_byte = diag_byte(cur2_s, volt2_s, ch2_tone_present_flag_s, tdet2_s, otf_s);
    end else begin
      tx_byte = {link.rd_ptr[`LNB_SEL_MSB-`LNB_SEL_LSB:0], link.shadow[link.rd_ptr[2:0]]};
    end
  end

  // Link engine: oversampled SCL and SDA, SDA pulled low only through the enable
  always_comb begin
    next_link = link;
    next_link.scl_q = scl_s;
    next_link.sda_q = sda_s;
    next_link.wr_valid = 1'b0;
    next_link.sda_level = 1'b0;
    if (!pg_link) begin
      next_link.state = LINK_IDLE;
      next_link.sda_oe = 1'b0;
      next_link.bit_cnt = '0;
      next_link.shadow = '0;
    end else if (start_seen) begin
      // Each transfer restarts the readback at the first register
      next_link.state = LINK_ADDR;
      next_link.bit_cnt = '0;
      next_link.sda_oe = 1'b0;
      next_link.rd_ptr = '0;
    end else if (stop_seen) begin
      next_link.state = LINK_IDLE;
      next_link.sda_oe = 1'b0;
    end else begin
      case (link.state)
        LINK_ADDR: begin
          if (scl_rise) begin
            next_link.shift = {link.shift[6:0], sda_s};
            next_link.bit_cnt = link.bit_cnt + `LNB_CNT_W'(1);
          end
          if (scl_fall && link.bit_cnt == `LNB_BITS_PER_BYTE) begin
            if (link.shift[7:1] == slave_addr) begin
              next_link.sda_oe = 1'b1;
              next_link.rw = link.shift[0];
              next_link.state = LINK_ADDR_ACK;
            end else begin
              next_link.state = LINK_IGNORE;
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (scl_fall) begin
            next_link.bit_cnt = '0;
            if (link.rw) begin
              // First read byte goes out MSB first
              next_link.shift = tx_byte;
              next_link.sda_oe = ~tx_byte[7];
              next_link.rd_ptr = bump_ptr(link.rd_ptr);
              next_link.state = LINK_RD_DATA;
            end else begin
              next_link.sda_oe = 1'b0;
              next_link.state = LINK_WR_DATA;
            end
          end
        end
        LINK_WR_DATA: begin
          if (scl_rise) begin
            next_link.shift = {link.shift[6:0], sda_s};
            next_link.bit_cnt = link.bit_cnt + `LNB_CNT_W'(1);
          end
          if (scl_fall && link.bit_cnt == `LNB_BITS_PER_BYTE) begin
            // Whole word lands at once, enable together with its control bits
            next_link.sda_oe = 1'b1;
            next_link.shadow[link.shift[`LNB_SEL_MSB:`LNB_SEL_LSB]] =
              link.shift[`LNB_REG_W-1:0];
            next_link.wr_valid = 1'b1;
            next_link.wr_word = link.shift;
            next_link.state = LINK_WR_ACK;
          end
        end
        LINK_WR_ACK: begin
          if (scl_fall) begin
            next_link.sda_oe = 1'b0;
            next_link.bit_cnt = '0;
            next_link.state = LINK_WR_DATA;
          end
        end
        LINK_RD_DATA: begin
          if (scl_fall) begin
            next_link.bit_cnt = link.bit_cnt + `LNB_CNT_W'(1);
            if (link.bit_cnt == `LNB_BITS_PER_BYTE - `LNB_CNT_W'(1)) begin
              // Release SDA for the master's ninth bit
              next_link.sda_oe = 1'b0;
              next_link.state = LINK_RD_ACK;
            end else begin
              next_link.shift = {link.shift[6:0], 1'b1};
              next_link.sda_oe = ~link.shift[6];
            end
          end
        end
        LINK_RD_ACK: begin
          if (scl_rise) begin
            next_link.master_ack = ~sda_s;
          end
          if (scl_fall) begin
            if (link.master_ack) begin
              next_link.shift = tx_byte;
              next_link.sda_oe = ~tx_byte[7];
              next_link.rd_ptr = bump_ptr(link.rd_ptr);
              next_link.bit_cnt = '0;
              next_link.state = LINK_RD_DATA;
            end else begin
              next_link.sda_oe = 1'b0;
              next_link.state = LINK_IGNORE;
            end
          end
        end
        LINK_IDLE, LINK_IGNORE: begin
          next_link.sda_oe = 1'b0;
        end
        default: begin
          next_link.state = LINK_IDLE;
          next_link.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Written words cross to the core domain; writes are far apart at any legal SCL rate
  word_cross #(
    .WIDTH(8)
  ) write_cross (
    .src_clk_in(link_clk_in),
    .src_valid_in(link.wr_valid),
    .src_data_in(link.wr_word),
    .dst_clk_in(core_clk_in),
    .dst_valid_out(wr_valid_core),
    .dst_data_out(wr_word_core),
    .reset_in(reset_in)
  );

  // Authoritative register bank that drives the power blocks
  always_comb begin
    next_core = core;
    if (!pg_core) begin
      next_core.bank = '0;
    end else if (wr_valid_core) begin
      next_core.bank[wr_word_core[`LNB_SEL_MSB:`LNB_SEL_LSB]] =
        wr_word_core[`LNB_REG_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // Outputs taken straight from flops
  assign sda_out = link.sda_level;
  assign sda_oe_out = link.sda_oe;
  assign ch1_output_enable_out = core.bank[`LNB_FIRST_REG][`LNB_EN_BIT];
  assign ch2_output_enable_out = core.bank[`LNB_SECOND_REG][`LNB_EN_BIT];
  assign ch1_control_out = core.bank[`LNB_FIRST_REG][3:0];
  assign ch2_control_out = core.bank[`LNB_SECOND_REG][3:0];
  assign config_regs_out = core.bank;
  assign interface_ready_out = pg_core;
endmodule

// *** sim/lnb_i2c_slave_readback_por_asserts.sv ***
// Port checker for the regulator controller I2C slave
`timescale 1ns/1ps
`include "lnb_i2c_regs.svh"
module lnb_i2c_slave_readback_por_asserts (
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic link_clk_in,
  input wire logic reset_in,
  // Bus and supply
  input wire logic scl_in,
  input wire logic power_good_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Channel control
  input wire logic ch1_output_enable_out,
  input wire logic ch2_output_enable_out,
  input wire logic [3:0] ch1_control_out,
  input wire logic [3:0] ch2_control_out,
  input wire logic [`LNB_NUM_SYS_REGS*`LNB_REG_W-1:0] config_regs_out,
  input wire logic interface_ready_out
);
  // Supply level held past the synchroniser depth
  sequence pg_low_run;
    !power_good_in [*6];
  endsequence
  sequence pg_high_run;
    power_good_in [*6];
  endsequence
  a_pg_release: assert property (
    @(posedge link_clk_in) disable iff (reset_in) pg_low_run |-> !sda_oe_out)
    else $error("sda pulled without supply");
  a_pg_clear: assert property (
    @(posedge core_clk_in) disable iff (reset_in) pg_low_run |->
    config_regs_out == '0 && !ch1_output_enable_out && !ch2_output_enable_out)
    else $error("registers not cleared without supply");
  a_ready_rise: assert property (
    @(posedge core_clk_in) disable iff (reset_in) pg_high_run |=> interface_ready_out)
    else $error("interface not ready with supply");
  a_ready_fall: assert property (
    @(posedge core_clk_in) disable iff (reset_in) pg_low_run |-> !interface_ready_out)
    else $error("interface ready without supply");
  a_enable_map: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    {ch2_output_enable_out, ch2_control_out, ch1_output_enable_out, ch1_control_out}
    == config_regs_out[9:0])
    else $error("channel outputs differ from registers");
  a_enable_late: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    $rose(ch1_output_enable_out) || $rose(ch2_output_enable_out) |-> interface_ready_out)
    else $error("enable rose while interface off");
  a_write_ready: assert property (
    @(posedge core_clk_in) disable iff (reset_in)
    $changed(config_regs_out) && config_regs_out != '0 |-> $past(interface_ready_out))
    else $error("register written while interface off");
  a_oe_scl_low: assert property (
    @(posedge link_clk_in) disable iff (reset_in) $changed(sda_oe_out) |-> !scl_in)
    else $error("sda changed while scl high");
  a_sda_open: assert property (
    @(posedge link_clk_in) disable iff (reset_in) sda_oe_out |-> sda_out == 1'b0)
    else $error("sda driven high");
endmodule

bind lnb_i2c_slave_readback_por lnb_i2c_slave_readback_por_asserts chk (
  .core_clk_in(core_clk_in), .link_clk_in(link_clk_in), .reset_in(reset_in),
  .scl_in(scl_in), .power_good_in(power_good_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .ch1_output_enable_out(ch1_output_enable_out),
  .ch2_output_enable_out(ch2_output_enable_out), .ch1_control_out(ch1_control_out),
  .ch2_control_out(ch2_control_out), .config_regs_out(config_regs_out),
  .interface_ready_out(interface_ready_out));

// *** sim/i2c_master_model.sv ***
// Host side bus master model; SCL rests high between frames
`timescale 1ns/1ps
module i2c_master_model (
  // Timing reference
  input wire logic clk_in,
  // Wire level and drives
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Wait n edges, then move just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One bit; data only moves while SCL is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    step(3);
    scl_out = 1'b1;
    repeat (5) @(posedge clk_in);
    r = sda_in; // Taken at the last edge of SCL high
    #1 scl_out = 1'b0;
    step(2);
  endtask
  // Start or repeated start from any SCL level
  task automatic start;
    sda_low_out = 1'b0;
    step(3);
    scl_out = 1'b1;
    step(3);
    sda_low_out = 1'b1;
    step(3);
    scl_out = 1'b0;
    step(2);
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    step(3);
    scl_out = 1'b1;
    step(3);
    sda_low_out = 1'b0;
    step(3);
  endtask
  // Eight bits MSB first, then the ninth clock for the ack
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
                         output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
endmodule

// *** sim/lnb_i2c_slave_readback_por_tb.sv ***
// Self-checking bench for the regulator controller I2C slave
`timescale 1ns/1ps
`include "lnb_i2c_regs.svh"
module lnb_i2c_slave_readback_por_tb;
  import lnb_i2c_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic pg = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [8:0] diag = 9'h000;
  logic scl, m_low, sda_oe, sda_o, sda, en1, en2, ready;
  logic [3:0] ctl1, ctl2;
  logic [39:0] cfg;
  logic [4:0] regs [8];
  int fail_count = 0;
  int comparisons = 0;
  // Pull-up wins unless a party pulls low
  assign sda = !(sda_oe || m_low);
  initial forever #10 core_clk = !core_clk;
  initial begin
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  lnb_i2c_slave_readback_por dut (.core_clk_in(core_clk), .link_clk_in(link_clk),
    .reset_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .addr_strap_low_in(strap[0]), .addr_strap_high_in(strap[1]), .power_good_in(pg),
    .overtemp_fault_flag_in(diag[0]), .ch1_current_range_flag_in(diag[1]),
    .ch2_current_range_flag_in(diag[2]), .ch1_voltage_range_flag_in(diag[3]),
    .ch2_voltage_range_flag_in(diag[4]), .ch1_tone_present_flag_in(diag[5]),
    .ch2_tone_present_flag_in(diag[6]), .ch1_tone_detect_pin_in(diag[7]),
    .ch2_tone_detect_pin_in(diag[8]), .ch1_output_enable_out(en1),
    .ch2_output_enable_out(en2), .ch1_control_out(ctl1), .ch2_control_out(ctl2),
    .config_regs_out(cfg), .interface_ready_out(ready));
  i2c_master_model host (.clk_in(core_clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(m_low));
  task automatic check(input logic [42:0] seen, input logic [42:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("%0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Start plus address byte; a refused address leaves SDA alone afterwards
  task automatic addr_phase(input logic [6:0] a, input logic rw, input logic acked);
    logic [7:0] r;
    logic k;
    host.start();
    host.byte_io({a, rw}, 1'b1, r, k);
    check(k, !acked, "address ack");
    if (!acked) host.byte_io(8'h00, 1'b1, r, k);
    if (!acked) check(k, 1'b1, "ack after refusal");
  endtask
  // Readback map: registers with pointer on top, then one flag byte per channel
  function automatic logic [7:0] model_byte(input int p);
    if (p < 8) return {3'(p), regs[p]};
    if (p == 8) return {3'h0, diag[7], diag[5], diag[3], diag[1], diag[0]};
    return {3'h0, diag[8], diag[6], diag[4], diag[2], diag[0]};
  endfunction
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
  initial begin
    logic [7:0] r;
    logic k;
    logic [39:0] e;
    void'($urandom(32'h206f2def));
    foreach (regs[i]) regs[i] = 5'h00;
    wait_c(8);
    rst = 1'b0;
    wait_c(3);
    check({cfg, en1, en2, ready}, 43'h0, "reset state");
    addr_phase(7'h08, 1'b0, 1'b0);
    host.stop();
    check(cfg, 40'h0, "regs while off");
    $display("test power_off done");
    pg = 1'b1;
    wait_c(4);
    check(ready, 1'b1, "ready");
    for (int s = 0; s < 4; s++) begin
      strap = 2'(s);
      wait_c(4);
      addr_phase(7'h08 | 7'(s), 1'b0, 1'b1);
      addr_phase(7'h08 | 7'(s ^ 1), 1'b0, 1'b0);
      host.stop();
    end
    $display("test address done");
    strap = 2'($urandom);
    // Pass one writes every register, pass two flips only channel one enable
    for (int pass = 0; pass < 2; pass++) begin
      addr_phase(7'h08 | 7'(strap), 1'b0, 1'b1);
      for (int sel = 0; sel < 8 - 7 * pass; sel++) begin
        regs[sel] = pass ? regs[sel] ^ 5'h10 : 5'($urandom);
        host.byte_io({3'(sel), regs[sel]}, 1'b1, r, k);
        check(k, 1'b0, "data ack");
      end
      host.stop();
      wait_c(8);
      for (int i = 0; i < 8; i++) e[5*i +: 5] = regs[i];
      check(cfg, e, "registers");
      check({en1, ctl1}, regs[0], "channel one");
      check({en2, ctl2}, regs[1], "channel two");
    end
    $display("test write done");
    for (int rep = 0; rep < 2; rep++) begin
      diag = 9'($urandom);
      wait_c(4);
      addr_phase(7'h08 | 7'(strap), 1'b1, 1'b1);
      for (int p = 0; p < 11; p++) begin
        host.byte_io(8'hff, p == 10, r, k);
        check(r, model_byte(p % 10), "read byte");
      end
      host.byte_io(8'hff, 1'b1, r, k);
      check(r, 8'hff, "released after nack");
      host.stop();
    end
    $display("test read done");
    pg = 1'b0;
    wait_c(8);
    check({cfg, en1, en2, ready}, 43'h0, "supply drop");
    addr_phase(7'h08 | 7'(strap), 1'b1, 1'b0);
    host.stop();
    $display("test supply_drop done");
    test_done();
  end
endmodule
